// ===== rtl/dswd_pkg.sv
/*
  constants, word layout, register map and helpers of the serial word decoder.
  assumes a 40 mhz pclk and a 32-channel, four-group device.
*/
// Contract
// - input, offset or gain write recalculates channel
// - three stages: 600, 600, 300 ns
// - calculation starts after the frame has closed
// - stage one repeats per channel, host waits
// - word: type 23..22, select 21..16, data 15..0
// - 14-bit variant: bits 1..0 forced zero
// - nonzero type writes data to chosen channels
// - 11 input, 10 offset, 01 gain, 00 special
// - bank bit picks input word a or b
// - high code 001..100 picks one group channel
// - high code 000: all, or whole group
// - high code 110: channel in all groups
// - high code 111: channel in groups 1..3
// - 24 bit clock falls, early frame end aborts
// - registers update on closing frame_sync rise
// - output-select bit picks output word a/b
package dswd_pkg;
   // timing
   localparam int PCLK_MHZ = 40;
   localparam int STG1_NS = 600;
   localparam int STG2_NS = 600;
   localparam int STG3_NS = 300;
   localparam int STG1_CYC = (STG1_NS * PCLK_MHZ + 999) / 1000;
   localparam int STG2_CYC = (STG2_NS * PCLK_MHZ + 999) / 1000;
   localparam int STG3_CYC = (STG3_NS * PCLK_MHZ + 999) / 1000;
   // serial word layout
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int WT_LSB = 22;
   localparam int CS_LSB = 16;
   localparam logic [1:0] WT_SPEC = 2'h0;
   localparam logic [1:0] WT_SLOPE = 2'h1;
   localparam logic [1:0] WT_ZERO = 2'h2;
   localparam logic [1:0] WT_INPUT = 2'h3;
   // channel_select high codes
   localparam logic [2:0] CS_BCAST = 3'h0;
   localparam logic [2:0] CS_GRP3 = 3'h4;
   localparam logic [2:0] CS_ALL4 = 3'h6;
   localparam logic [2:0] CS_G123 = 3'h7;
   // apb register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_LAST = 8'h08;
   localparam logic [7:0] ADDR_OSEL0 = 8'h0c;
   localparam logic [7:0] ADDR_CHSEL = 8'h1c;
   localparam logic [7:0] ADDR_CHDAT = 8'h20;
   localparam int CTRL_BANK = 0;
   // reset values
   localparam logic [15:0] RST_INPUT = 16'h0000;
   localparam logic [15:0] RST_ZERO = 16'h8000;
   localparam logic [15:0] RST_SLOPE = 16'hffff;
   localparam logic [15:0] RST_OUT = 16'h0000;
   localparam logic [31:0] RST_OSEL = 32'h0000_0000;

   // lowest set bit of a channel mask
   function automatic logic [4:0] lowest(input logic [31:0] m);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (m[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction
endpackage

// ===== rtl/dswd_if.sv
/*
  carrier between the frame receiver, the calculation sequencer and the core.
  assumes all three sit on pclk.
*/
`timescale 1ns/1ps
interface dswd_if;
   logic word_valid; // one-cycle pulse, complete frame
   logic word_abort; // one-cycle pulse, short frame
   logic [23:0] word; // last complete frame
   logic start; // core hands a channel mask over
   logic [31:0] mask; // channels to recalculate
   logic ready; // sequencer can take a mask
   logic busy; // any stage running
   logic [4:0] chan; // channel in stage one
   logic ch_done; // stage one of chan ends
   modport rx (output word_valid, word_abort, word);
   modport seq (input start, mask, output ready, busy, chan, ch_done);
   modport core (input word_valid, word_abort, word, ready, busy, chan, ch_done,
      output start, mask);
endinterface

// ===== rtl/dswd_frame_rx.sv
/*
  serial frame receiver: oversamples frame_sync_n, bit_clk and ser_din.
  assumes bit_clk is at most a quarter of pclk.
*/
`timescale 1ns/1ps
module dswd_frame_rx (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // serial pins, asynchronous
   input wire logic frame_sync_n,
   input wire logic bit_clk,
   input wire logic ser_din,
   // frames out
   dswd_if.rx rif
);
   logic [2:0] meta_r; // first synchroniser stage
   logic [2:0] sync_r; // {sync, clk, din} safe copy
   logic [1:0] prev_r; // {sync, clk} one cycle older
   logic act_r; // frame open
   logic [4:0] cnt_r; // falling edges seen, saturates
   logic [23:0] shf_r; // shift register
   logic vld_r, abt_r;
   logic [23:0] word_r;

   wire sync_fall = prev_r[1] & ~sync_r[2];
   wire sync_rise = ~prev_r[1] & sync_r[2];
   wire clk_fall = prev_r[0] & ~sync_r[1];
   wire full = cnt_r >= dswd_pkg::FRAME_BITS;
   wire close_ok = sync_rise & act_r & full;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 3'h7;
         sync_r <= 3'h7;
         prev_r <= 2'h3;
      end else begin
         meta_r <= {frame_sync_n, bit_clk, ser_din};
         sync_r <= meta_r;
         prev_r <= sync_r[2:1];
      end
   end

   // shift on falling bit_clk inside a frame; extra edges corrupt the word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_r <= 1'b0;
         cnt_r <= 5'h00;
         shf_r <= 24'h000000;
      end else if (sync_fall) begin
         act_r <= 1'b1;
         cnt_r <= 5'h00;
      end else if (sync_rise) begin
         act_r <= 1'b0;
      end else if (act_r && clk_fall) begin
         shf_r <= {shf_r[22:0], sync_r[0]};
         cnt_r <= (cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h01;
      end
   end

   // closing edge: full frame hands over, short frame aborts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vld_r <= 1'b0;
         abt_r <= 1'b0;
         word_r <= 24'h000000;
      end else begin
         vld_r <= close_ok;
         abt_r <= sync_rise & act_r & ~full;
         if (close_ok) begin
            word_r <= shf_r;
         end
      end
   end

   assign rif.word_valid = vld_r;
   assign rif.word_abort = abt_r;
   assign rif.word = word_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_short_abort: assert property (@(posedge pclk) disable iff (!presetn)
      (sync_rise && act_r && !full) |=> (abt_r && !vld_r))
      else $error("short frame not aborted");
   a_frame_word: assert property (@(posedge pclk) disable iff (!presetn)
      close_ok |=> (vld_r && word_r == $past(shf_r)))
      else $error("full frame not handed over");
endmodule

// ===== rtl/dswd_calc_seq.sv
/*
  calculation sequencer: stage one per channel, then stages two and three.
  assumes the core only raises start with a nonzero mask.
*/
`timescale 1ns/1ps
module dswd_calc_seq (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // core side
   dswd_if.seq cif
);
   localparam int S1C = dswd_pkg::STG1_CYC;
   localparam int S2C = dswd_pkg::STG2_CYC;
   localparam int S3C = dswd_pkg::STG3_CYC;
   typedef enum logic [1:0] {ST_IDLE, ST_S1, ST_S2, ST_S3} dswd_stg_e;
   dswd_stg_e st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt; // cycles left in stage
   logic [31:0] left_r, left_nxt; // channels still waiting
   logic [4:0] chan_r, chan_nxt;

   wire last = cnt_r == 8'h01;
   wire take = cif.start & cif.ready;
   wire [31:0] rest = left_r & ~(32'h1 << chan_r);

   assign cif.ready = st_r != ST_S1;
   assign cif.busy = st_r != ST_IDLE;
   assign cif.chan = chan_r;
   assign cif.ch_done = (st_r == ST_S1) & last;

   ////////////////////////////////////////////////////////////////////////////
   // next state; a new mask restarts stage one, dropping stage two or three
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r - 8'h01;
      left_nxt = left_r;
      chan_nxt = chan_r;
      if (take) begin
         st_nxt = ST_S1;
         cnt_nxt = 8'(S1C);
         left_nxt = cif.mask;
         chan_nxt = dswd_pkg::lowest(cif.mask);
      end else if (last) begin
         unique case (st_r)
            ST_S1: begin
               left_nxt = rest;
               if (rest != 32'h0) begin
                  cnt_nxt = 8'(S1C);
                  chan_nxt = dswd_pkg::lowest(rest);
               end else begin
                  st_nxt = ST_S2;
                  cnt_nxt = 8'(S2C);
               end
            end
            ST_S2: begin
               st_nxt = ST_S3;
               cnt_nxt = 8'(S3C);
            end
            ST_S3: st_nxt = ST_IDLE;
            ST_IDLE: cnt_nxt = cnt_r;
         endcase
      end else if (st_r == ST_IDLE) begin
         cnt_nxt = cnt_r;
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_IDLE;
         cnt_r <= 8'h00;
         left_r <= 32'h0;
         chan_r <= 5'h00;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         left_r <= left_nxt;
         chan_r <= chan_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_stage1_len: assert property (@(posedge pclk) disable iff (!presetn)
      take |-> ##S1C cif.ch_done)
      else $error("stage one length wrong");
   a_stage2_len: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_r == ST_S3) |-> $past(st_r == ST_S2, S2C))
      else $error("stage two length wrong");
   a_stage3_len: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(cif.busy) |-> $past(st_r == ST_S3, S3C))
      else $error("stage three length wrong");
   a_chan_ascend: assert property (@(posedge pclk) disable iff (!presetn)
      (cif.ch_done && rest != 32'h0 && !take) |=> (st_r == ST_S1 && chan_r > $past(chan_r)))
      else $error("channels not in ascending order");
   c_multi_chan: cover property (@(posedge pclk) disable iff (!presetn)
      cif.ch_done ##S1C cif.ch_done);
   c_tail_done: cover property (@(posedge pclk) disable iff (!presetn) $fell(cif.busy));
endmodule

// ===== rtl/dswd_top.sv
/*
  serial command word decoder of a 32-channel dac with an apb register window.
  assumes an apb master on pclk and a host driving the three serial pins.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module dswd_top #(
   parameter int DATA_BITS = 16 // 16 or 14 data bits
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   input wire logic frame_sync_n,
   input wire logic bit_clk,
   input wire logic ser_din
);
   // only the two word widths are served
   if (!(DATA_BITS == 16 || DATA_BITS == 14)) begin : g_chk
      $error("DATA_BITS must be 16 or 14");
   end

   // one carrier joins receiver, sequencer and core
   dswd_if dif ();

   // channel register arrays
   // flat arrays: the window read stays a plain mux
   logic [15:0] in_a [32]; // input_word_a
   logic [15:0] in_b [32]; // input_word_b
   logic [15:0] zs [32]; // zero_shift
   logic [15:0] sl [32]; // slope_value
   logic [15:0] oa [32]; // output_word_a
   logic [15:0] ob [32]; // output_word_b

   // software registers
   logic ctrl_r; // bank_choice
   logic [31:0] osel_r; // four output-select bytes
   logic [7:0] chsel_r; // {array, channel} for the window
   logic [23:0] last_r; // last accepted word
   logic [31:0] pend_r; // channels waiting for the engine
   logic [31:0] prdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // sub-blocks
   // frame receiver: one pulse per complete frame
   dswd_frame_rx u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .frame_sync_n(frame_sync_n),
      .bit_clk(bit_clk),
      .ser_din(ser_din),
      .rif(dif.rx)
   );

   // sequencer: timing of the three stages
   dswd_calc_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .cif(dif.seq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // word decode
   wire [1:0] wtype = dif.word[dswd_pkg::WT_LSB +: 2];
   wire [5:0] wcs = dif.word[dswd_pkg::CS_LSB +: 6];
   wire [2:0] hi = wcs[5:3];
   wire [2:0] lo = wcs[2:0];

   // single codes: high code less one is the group
   wire [2:0] hi_m1 = hi - 3'h1;
   wire [2:0] lo_m1 = lo - 3'h1;
   wire [31:0] m_single = 32'h1 << {hi_m1[1:0], lo};
   wire [31:0] m_group = 32'h0000_00ff << {lo_m1[1:0], 3'h0};
   wire [31:0] m_all4 = 32'h0101_0101 << lo;
   wire [31:0] m_g123 = 32'h0101_0100 << lo;

   // high code 000: low bits name a group, 0 all
   wire [31:0] m_bcast = (lo == 3'h0) ? 32'hffff_ffff
      : (lo <= dswd_pkg::CS_GRP3) ? m_group : 32'h0;

   // reserved codes give an empty mask
   wire [31:0] dec_mask = (hi == dswd_pkg::CS_BCAST) ? m_bcast
      : (hi <= dswd_pkg::CS_GRP3) ? m_single
      : (hi == dswd_pkg::CS_ALL4) ? m_all4
      : (hi == dswd_pkg::CS_G123) ? m_g123 : 32'h0;

   // special-function words are not handled here and pass untouched
   wire word_ok = dif.word_valid & (wtype != dswd_pkg::WT_SPEC)
      & (dec_mask != 32'h0);

   // one strobe per register kind
   wire wr_in = word_ok & (wtype == dswd_pkg::WT_INPUT);
   wire wr_xa = wr_in & ~ctrl_r;
   wire wr_xb = wr_in & ctrl_r;
   wire wr_zs = word_ok & (wtype == dswd_pkg::WT_ZERO);
   wire wr_sl = word_ok & (wtype == dswd_pkg::WT_SLOPE);

   // the narrow variant keeps its two low bits at zero
   wire [15:0] wr_data = (DATA_BITS == 14) ? {dif.word[15:2], 2'h0} : dif.word[15:0];

   // channel registers take the frame on its closing edge
   // an empty mask leaves every channel alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 32; i++) begin
            in_a[i] <= dswd_pkg::RST_INPUT;
            in_b[i] <= dswd_pkg::RST_INPUT;
            zs[i] <= dswd_pkg::RST_ZERO;
            sl[i] <= dswd_pkg::RST_SLOPE;
         end
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (dec_mask[i]) begin
               if (wr_xa) in_a[i] <= wr_data;
               if (wr_xb) in_b[i] <= wr_data;
               if (wr_zs) zs[i] <= wr_data;
               if (wr_sl) sl[i] <= wr_data;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pending channels: a new word adds to the set even as it is handed over
   // the mask waits here while stage one runs
   assign dif.start = dif.ready & (pend_r != 32'h0);
   assign dif.mask = pend_r;
   // a clear and a new word in one cycle: the word wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= 32'h0;
      end else begin
         pend_r <= (dif.start ? 32'h0 : pend_r) | (word_ok ? dec_mask : 32'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output calculation: x * (gain + 1) / 2^16 + offset - 2^15, clamped
   // one channel at a time, named by dif.chan
   // the clamp keeps an offset from wrapping the code
   wire sel_b = osel_r[dif.chan];
   wire [15:0] cx = sel_b ? in_b[dif.chan] : in_a[dif.chan];
   wire [16:0] gain = {1'b0, sl[dif.chan]} + 17'h00001;
   wire [32:0] prod = 33'(cx * gain);
   wire signed [18:0] sum = $signed({2'h0, prod[32:16]}) + $signed({3'h0, zs[dif.chan]})
      - 19'sh08000;
   wire [15:0] clamp = sum[18] ? 16'h0000 : (sum[17:16] != 2'h0) ? 16'hffff : sum[15:0];

   wire [15:0] result = (DATA_BITS == 14) ? {clamp[15:2], 2'h0} : clamp;

   // the selected output word of the channel takes the result
   // the other output word keeps its value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 32; i++) begin
            oa[i] <= dswd_pkg::RST_OUT;
            ob[i] <= dswd_pkg::RST_OUT;
         end
      end else if (dif.ch_done) begin
         if (sel_b) ob[dif.chan] <= result;
         else oa[dif.chan] <= result;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb decode: no wait state, read data captured in the setup cycle
   // setup catches read data; access writes
   wire setup = psel & ~penable;
   wire acc_wr = psel & penable & pwrite;
   wire [7:0] os_off = paddr - dswd_pkg::ADDR_OSEL0;

   // address hits; a miss answers with an error
   wire hit_ctrl = paddr == dswd_pkg::ADDR_CTRL;
   wire hit_stat = paddr == dswd_pkg::ADDR_STAT;
   wire hit_last = paddr == dswd_pkg::ADDR_LAST;
   wire hit_os = (os_off < 8'h10) & (os_off[1:0] == 2'h0);
   wire hit_chsel = paddr == dswd_pkg::ADDR_CHSEL;
   wire hit_chdat = paddr == dswd_pkg::ADDR_CHDAT;
   wire hit_any = hit_ctrl | hit_stat | hit_last | hit_os | hit_chsel | hit_chdat;

   // window: array code picks the word, 6 and 7 read 0
   wire [4:0] wch = chsel_r[4:0];
   wire [2:0] warr = chsel_r[7:5];
   wire [15:0] win = (warr == 3'h0) ? in_a[wch] : (warr == 3'h1) ? in_b[wch]
      : (warr == 3'h2) ? zs[wch] : (warr == 3'h3) ? sl[wch]
      : (warr == 3'h4) ? oa[wch] : (warr == 3'h5) ? ob[wch] : 16'h0000;

   // read mux: an or of one-hot terms
   wire [31:0] rd_val = ({32{hit_ctrl}} & {31'h0, ctrl_r})
      | ({32{hit_stat}} & {25'h0, dif.chan, pend_r != 32'h0, dif.busy})
      | ({32{hit_last}} & {8'h00, last_r})
      | ({32{hit_os}} & {24'h0, osel_r[{os_off[3:2], 3'h0} +: 8]})
      | ({32{hit_chsel}} & {24'h0, chsel_r})
      | ({32{hit_chdat}} & {16'h0, win});

   // no wait state: every access cycle is the last
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata = prdata_r;

   // software registers; status, last word and window are read-only
   // read data is caught in setup, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 1'b0;
         osel_r <= dswd_pkg::RST_OSEL;
         chsel_r <= 8'h00;
         prdata_r <= 32'h0;
      end else begin
         if (setup) prdata_r <= rd_val;
         if (acc_wr && hit_ctrl) ctrl_r <= pwdata[dswd_pkg::CTRL_BANK];
         if (acc_wr && hit_chsel) chsel_r <= pwdata[7:0];
         if (acc_wr && hit_os) osel_r[{os_off[3:2], 3'h0} +: 8] <= pwdata[7:0];
      end
   end

   // last accepted word, for software to inspect
   // special and reserved words leave it alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_r <= 24'h000000;
      end else if (word_ok) begin
         last_r <= dif.word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // one clock domain: shared clocking and disable
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_rsv_ignored: assert property (
      (dif.word_valid && hi == 3'h5) |-> (!word_ok ##1 $stable(last_r)))
      else $error("reserved select code wrote registers");

   a_single_map: assert property (
      (word_ok && hi == 3'h2) |-> dec_mask == (32'h1 << (5'h08 + 5'(lo))))
      else $error("group 1 single channel decoded wrong");

   a_all_groups: assert property (
      (word_ok && hi == dswd_pkg::CS_ALL4) |-> ($countones(dec_mask) == 4 && dec_mask[lo]))
      else $error("channel in all groups decoded wrong");

   a_skip_group0: assert property (
      (word_ok && hi == dswd_pkg::CS_G123) |-> ($countones(dec_mask) == 3
         && dec_mask[7:0] == 8'h00))
      else $error("group 0 touched by groups 1..3 code");

   a_bcast_all: assert property (
      (dif.word_valid && wcs == 6'h00 && wtype != dswd_pkg::WT_SPEC) |-> dec_mask == 32'hffff_ffff)
      else $error("broadcast did not select all channels");

   a_bank_route: assert property (
      (wr_in && !ctrl_r && dec_mask[0]) |=> in_a[0] == $past(wr_data))
      else $error("input write missed input_word_a");

   a_recalc_start: assert property (
      (word_ok && !dif.busy && pend_r == 32'h0) |=> dif.start ##24 dif.ch_done)
      else $error("write did not start a recalculation");

   a_narrow_zero: assert property (
      (DATA_BITS == 14 && dif.ch_done) |=> (oa[$past(dif.chan)][1:0] == 2'h0
         && ob[$past(dif.chan)][1:0] == 2'h0))
      else $error("narrow variant low bits not zero");

   a_osel_b: assert property (
      (dif.ch_done && sel_b) |=> ob[$past(dif.chan)] == $past(result))
      else $error("output_word_b not updated");

   a_osel_a: assert property (
      (dif.ch_done && !sel_b) |=> oa[$past(dif.chan)] == $past(result))
      else $error("output_word_a not updated");

   a_group_map: assert property (
      (word_ok && hi == 3'h0 && lo != 3'h0) |->
         ($countones(dec_mask) == 8 && dec_mask[8 * (int'(lo) - 1)]))
      else $error("whole group decoded wrong");

   a_pend_keep: assert property (
      (word_ok && dif.start) |=> pend_r == $past(dec_mask))
      else $error("write lost while mask handed over");

   a_zero_route: assert property (
      (wr_zs && dec_mask[27]) |=> zs[27] == $past(wr_data))
      else $error("offset write missed zero_shift");

   a_bank_b: assert property (
      (wr_xb && dec_mask[10]) |=> in_b[10] == $past(wr_data))
      else $error("input write missed input_word_b");

   a_spec_ignored: assert property (
      (dif.word_valid && wtype == dswd_pkg::WT_SPEC) |=> $stable(last_r))
      else $error("special word treated as data");

   a_last_word: assert property (
      word_ok |=> last_r == $past(dif.word))
      else $error("accepted word not kept");

   c_single_write: cover property (word_ok && $countones(dec_mask) == 1);
   c_group_write: cover property (word_ok && hi == dswd_pkg::CS_BCAST);
   c_apb_read: cover property (pready && !pwrite && hit_chdat);
endmodule

// ===== tb/dswd_host.sv
/*
  host serial controller model: frames of 24 bits, msb first, 200 ns bit clock.
  assumes pclk at 40 mhz; the bench spaces frames by waiting for the engine.
*/
`timescale 1ns/1ps
module dswd_host (
   // clock
   input wire logic pclk,
   // serial pins towards the device
   output logic frame_sync_n,
   output logic bit_clk,
   output logic ser_din
);
   // idle: strobe high, clock parked high
   initial begin
      frame_sync_n = 1'b1;
      bit_clk = 1'b1;
      ser_din = 1'b0;
   end
   // one frame; nf below 24 gives a cut-short frame
   task send(input logic [23:0] w, input int nf);
      @(posedge pclk) frame_sync_n <= 1'b0;
      for (int i = 0; i < nf; i++) begin
         ser_din <= w[23 - i];
         repeat (4) @(posedge pclk);
         bit_clk <= 1'b0;
         repeat (4) @(posedge pclk);
         bit_clk <= 1'b1;
      end
      repeat (4) @(posedge pclk);
      frame_sync_n <= 1'b1;
      ser_din <= ~ser_din; // released line shows no stale bit
      repeat (4) @(posedge pclk);
   endtask
endmodule

// ===== tb/testbench.sv
/*
  self-checking bench: apb reads through the channel window, serial frames from the host.
  assumes the default 16 data bits and one-cycle apb access.
*/
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, err_seen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr;
   wire frame_sync_n, bit_clk, ser_din;
   int error_cnt, tests_run, cyc, t0;
   dswd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_sync_n(frame_sync_n), .bit_clk(bit_clk), .ser_din(ser_din));
   dswd_host i_host (.pclk(pclk), .frame_sync_n(frame_sync_n), .bit_clk(bit_clk),
      .ser_din(ser_din));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; request held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // read one word of one channel through the window
   task rdch(input logic [2:0] arr, input int ch, input logic [15:0] exp);
      apb(1'b1, 8'h1c, {24'h0, arr, 5'(ch)});
      apb(1'b0, 8'h20, 32'h0);
      chk($sformatf("arr%0d ch%0d", arr, ch), rd, {16'h0, exp});
   endtask
   // wait until the calculation engine is idle, which also spaces frames
   task idle;
      rd = 32'h1;
      for (int i = 0; i < 400 && rd[0] !== 1'b0; i++) apb(1'b0, 8'h04, 32'h0);
      chk("idle", {31'h0, rd[0]}, 32'h0);
   endtask
   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; error_cnt = 0; tests_run = 0; cyc = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      // reset values and an unmapped place
      apb(1'b0, 8'h00, 32'h0); chk("ctrl", rd, 32'h0);
      rdch(3'h2, 5, 16'h8000);
      rdch(3'h3, 31, 16'hffff);
      apb(1'b0, 8'h40, 32'h0); chk("slverr", {31'h0, err_seen}, 32'h1);
      $display("test reset done");
      // single channel input write: group 1 channel 2
      i_host.send(24'hd21234, 24); idle();
      apb(1'b0, 8'h08, 32'h0); chk("last", rd, 32'h00d21234);
      rdch(3'h0, 10, 16'h1234);
      rdch(3'h4, 10, 16'h1234);
      // bank bit steers to input word b
      apb(1'b1, 8'h00, 32'h1);
      i_host.send(24'hd2abcd, 24); idle();
      rdch(3'h1, 10, 16'habcd);
      rdch(3'h0, 10, 16'h1234);
      // cut-short frame writes nothing
      i_host.send(24'hc95555, 23); idle();
      apb(1'b0, 8'h08, 32'h0); chk("abort", rd, 32'h00d2abcd);
      $display("test single done");
      // addressing modes on the offset word, then one single-channel gain write
      i_host.send({2'b10, 6'o63, 16'h8001}, 24); idle();
      for (int g = 0; g < 4; g++) rdch(3'h2, g * 8 + 3, 16'h8001);
      i_host.send({2'b10, 6'o74, 16'h8002}, 24); idle();
      rdch(3'h2, 4, 16'h8000);
      rdch(3'h2, 28, 16'h8002);
      i_host.send({2'b10, 6'o02, 16'h8003}, 24); idle();
      rdch(3'h2, 15, 16'h8003);
      rdch(3'h2, 7, 16'h8000);
      i_host.send({2'b10, 6'o51, 16'h1111}, 24); idle();
      i_host.send({2'b10, 6'o05, 16'h1111}, 24); idle();
      rdch(3'h2, 1, 16'h8000);
      rdch(3'h2, 5, 16'h8000);
      i_host.send({2'b01, 6'o11, 16'h7fff}, 24); idle();
      rdch(3'h3, 1, 16'h7fff);
      $display("test addressing done");
      // broadcast gain write: stage one for all 32 channels, then 24 and 12
      i_host.send({2'b01, 6'o00, 16'hffff}, 24);
      t0 = cyc;
      idle();
      chk("bcast_time", {31'h0, (cyc - t0) >= 800 && (cyc - t0) <= 830}, 32'h1);
      rdch(3'h3, 1, 16'hffff);
      $display("test broadcast done");
      // output-select bit of channel 10 steers its recalculation to word b
      apb(1'b1, 8'h10, 32'h4);
      apb(1'b0, 8'h10, 32'h0);
      chk("osel1", rd, 32'h4);
      i_host.send({2'b11, 6'o22, 16'h4000}, 24);
      idle();
      rdch(3'h5, 10, 16'h4003);
      rdch(3'h4, 10, 16'h1237);
      $display("test select done");
      results();
   end
endmodule
